/* rtl/ccgr_busedge.sv */
`timescale 1ns/100ps
module ccgr_busedge (
  input wire logic core_clk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic scl_in, // serial clock pin level
  input wire logic sda_in, // serial data pin level
  output logic sda_level, // registered data level
  output logic scl_rise, // clock rising edge pulse
  output logic scl_fall, // clock falling edge pulse
  output logic start_det, // start or repeated start pulse
  output logic stop_det // stop condition pulse
);

  logic scl_q;
  logic scl_prev_q;
  logic sda_q;
  logic sda_prev_q;

  // sample pins, idle bus reads high
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_q <= 1'b1;
      scl_prev_q <= 1'b1;
      sda_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      scl_prev_q <= scl_q;
      sda_q <= sda_in;
      sda_prev_q <= sda_q;
    end
  end

  // edge and bus condition decode
  assign sda_level = sda_q;
  assign scl_rise = scl_q & ~scl_prev_q;
  assign scl_fall = ~scl_q & scl_prev_q;
  assign start_det = scl_q & scl_prev_q & sda_prev_q & ~sda_q;
  assign stop_det = scl_q & scl_prev_q & ~sda_prev_q & sda_q;

endmodule

/* rtl/ccgr_outctl.sv */
`timescale 1ns/100ps
module ccgr_outctl #(
  parameter int NUM_OUT = 4
) (
  input wire logic core_clk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic powerdown, // device power-down level
  input wire logic ref_enable, // reference soft enable
  input wire logic ref_wake, // reference runs in power-down
  input wire logic [1:0] stop_sel, // disabled output state
  input wire logic [NUM_OUT-1:0] soft_en, // per-output soft enables
  input wire logic [NUM_OUT-1:0] pin_en_n, // per-output enable pins, low on
  output logic ref_clk_run, // reference clock passes
  output logic ref_hold_level, // reference held level
  output logic ref_hold_hiz, // reference held floating
  output logic [NUM_OUT-1:0] dif_run, // differential outputs running
  output logic dif_stop_true, // stopped true leg level
  output logic dif_stop_comp, // stopped complement leg level
  output logic dif_stop_hiz // stopped legs floating
);

  // ****************************************
  // reference output
  // ****************************************
  // gate and held state of the reference
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_clk_run <= 1'b0;
      ref_hold_level <= 1'b0;
      ref_hold_hiz <= 1'b0;
    end else begin
      ref_clk_run <= ref_enable & (~powerdown | ref_wake);
      ref_hold_level <= (stop_sel == ccgr_pkg::STOP_LO_HI);
      ref_hold_hiz <= (stop_sel == ccgr_pkg::STOP_HIZ);
    end
  end

  // ****************************************
  // differential outputs
  // ****************************************
  // soft enable low beats the pin
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dif_run <= '0;
    end else begin
      dif_run <= soft_en & ~pin_en_n & {NUM_OUT{~powerdown}};
    end
  end

  // leg levels while stopped
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dif_stop_true <= 1'b0;
      dif_stop_comp <= 1'b0;
      dif_stop_hiz <= 1'b0;
    end else begin
      dif_stop_true <= (stop_sel == ccgr_pkg::STOP_HI_LO);
      dif_stop_comp <= (stop_sel == ccgr_pkg::STOP_LO_HI);
      dif_stop_hiz <= (stop_sel == ccgr_pkg::STOP_HIZ);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_ref_wake_run: assert property (@(posedge core_clk) disable iff (!reset_n)
    powerdown && ref_enable |=> ref_clk_run == $past(ref_wake))
    else $error("reference gate wrong in power-down");

  a_ref_held_high: assert property (@(posedge core_clk) disable iff (!reset_n)
    !ref_enable && stop_sel == 2'h3 |=> !ref_clk_run && ref_hold_level && !ref_hold_hiz)
    else $error("disabled reference not held high");

  a_dif_override: assert property (@(posedge core_clk) disable iff (!reset_n)
    !soft_en[0] && !pin_en_n[0] |=> !dif_run[0])
    else $error("soft enable did not override pin");

  a_dif_stop_legs: assert property (@(posedge core_clk) disable iff (!reset_n)
    stop_sel == 2'h2 |=> dif_stop_true && !dif_stop_comp && !dif_stop_hiz)
    else $error("stopped legs not high/low");

endmodule

/* rtl/ccgr_pkg.sv */
// Contract
// - reference wake bit keeps it running in power-down
// - reference enable bit; disabled holds stop-state level
// - indices 4, 8, 9 are reserved, no function
// - index 5 read-only revision and vendor codes
// - index 6 read-only device class and identifier
// - five-bit read length, resets to 8, writable
// - divider programming enable, variant-dependent reset value
// - retain bit clear: power-down restores defaults
// - stop-state field picks disabled differential levels
// - index 12 holds four two-bit impedance selectors
// - impedance reset value depends on device variant
// - soft enable low overrides pin, forces stop state
// - block read sends count, then consecutive bytes
package ccgr_pkg;

  // ****************************************
  // register indices
  // ****************************************
  localparam logic [7:0] OFF_REF_CTRL = 8'h03;
  localparam logic [7:0] OFF_RSVD_4 = 8'h04;
  localparam logic [7:0] OFF_REV_VENDOR = 8'h05;
  localparam logic [7:0] OFF_CLASS_ID = 8'h06;
  localparam logic [7:0] OFF_READ_LEN = 8'h07;
  localparam logic [7:0] OFF_RSVD_8 = 8'h08;
  localparam logic [7:0] OFF_RSVD_9 = 8'h09;
  localparam logic [7:0] OFF_DIV_RETAIN = 8'h0A;
  localparam logic [7:0] OFF_STOP_STATE = 8'h0B;
  localparam logic [7:0] OFF_IMPEDANCE = 8'h0C;

  // ****************************************
  // field positions
  // ****************************************
  localparam int REF_SLEW_LSB = 6;
  localparam int REF_WAKE_BIT = 5;
  localparam int REF_EN_BIT = 4;
  localparam int DIV_EN_BIT = 7;
  localparam int RETAIN_BIT = 6;
  localparam int READ_LEN_W = 5;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [1:0] REF_SLEW_RST = 2'h1;
  localparam logic REF_WAKE_RST = 1'h0;
  localparam logic REF_EN_RST = 1'h1;
  localparam logic [4:0] READ_LEN_RST = 5'h08;
  localparam logic DIV_EN_RST = 1'h0;
  localparam logic DIV_EN_FACTORY_RST = 1'h1;
  localparam logic RETAIN_RST = 1'h1;
  localparam logic [1:0] STOP_RST = 2'h0;
  localparam logic [7:0] IMP_100_RST = 8'hAA;
  localparam logic [7:0] IMP_85_RST = 8'h55;

  // ****************************************
  // stop-state encodings
  // ****************************************
  localparam logic [1:0] STOP_LOW = 2'h0;
  localparam logic [1:0] STOP_HIZ = 2'h1;
  localparam logic [1:0] STOP_HI_LO = 2'h2;
  localparam logic [1:0] STOP_LO_HI = 2'h3;

  // ****************************************
  // serial bus
  // ****************************************
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h68;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

endpackage

/* rtl/ccgr_top.sv */
`timescale 1ns/100ps
module ccgr_top #(
  parameter int NUM_OUT = 4,
  parameter logic [7:0] IMP_RESET = ccgr_pkg::IMP_100_RST, // 85-ohm part: IMP_85_RST
  parameter logic DIV_EN_RESET = ccgr_pkg::DIV_EN_RST, // factory part: DIV_EN_FACTORY_RST
  parameter logic [3:0] REVISION = 4'h3, // arbitrary value
  parameter logic [3:0] VENDOR = 4'h5, // arbitrary value
  parameter logic [1:0] DEV_CLASS = 2'h2, // arbitrary value
  parameter logic [5:0] DEV_ID = 6'h15 // arbitrary value
) (
  input wire logic core_clk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic smb_clk_in, // serial clock pin
  input wire logic smb_data_in, // serial data pin level
  output logic smb_data_out, // serial data drive value
  output logic smb_data_oe, // serial data pull-low enable
  input wire logic addr_sel, // slave address select strap
  input wire logic powerdown, // power-down level, high active
  input wire logic [NUM_OUT-1:0] out_soft_enable, // per-output soft enables
  input wire logic [NUM_OUT-1:0] out_enable_pin_n, // per-output enable pins
  output logic ref_clk_run, // reference clock passes
  output logic ref_hold_level, // reference held level
  output logic ref_hold_hiz, // reference held floating
  output logic [1:0] ref_slew_sel, // reference slew select
  output logic [NUM_OUT-1:0] dif_run, // differential outputs running
  output logic dif_stop_true, // stopped true leg level
  output logic dif_stop_comp, // stopped complement leg level
  output logic dif_stop_hiz, // stopped legs floating
  output logic divider_prog_enable, // divider programming allowed
  output logic [7:0] out_impedance_sel // impedance, two bits per output
);

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_INDEX, S_COUNT, S_WDATA, S_ACK, S_RDATA, S_RACK
  } ccgr_state_e;

  ccgr_state_e state_q;
  ccgr_state_e ack_next_q;
  logic [3:0] cnt_q;
  logic [7:0] shreg_q;
  logic [7:0] tx_q;
  logic [7:0] index_q;
  logic [7:0] wr_left_q;
  logic [7:0] wr_data_q;
  logic wr_pend_q;
  logic first_q;
  logic mack_q;
  logic sda_drv_q;
  logic sda_out_q;
  logic ref_wake_q;
  logic ref_en_q;
  logic [4:0] read_len_q;
  logic retain_q;
  logic [1:0] stop_sel_q;
  logic sda_level;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [6:0] my_addr;
  logic [7:0] load_byte;
  logic wr_fire;
  logic pd_clear;

  // ****************************************
  // register read map
  // ****************************************
  // reserved and unmapped indices read zero
  function automatic logic [7:0] reg_rd(input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      ccgr_pkg::OFF_REF_CTRL: v = {ref_slew_sel, ref_wake_q, ref_en_q, 4'h0};
      ccgr_pkg::OFF_REV_VENDOR: v = {REVISION, VENDOR};
      ccgr_pkg::OFF_CLASS_ID: v = {DEV_CLASS, DEV_ID};
      ccgr_pkg::OFF_READ_LEN: v = {3'h0, read_len_q};
      ccgr_pkg::OFF_DIV_RETAIN: v = {divider_prog_enable, retain_q, 6'h00};
      ccgr_pkg::OFF_STOP_STATE: v = {6'h00, stop_sel_q};
      ccgr_pkg::OFF_IMPEDANCE: v = out_impedance_sel;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ****************************************
  // bus pin edges
  // ****************************************
  ccgr_busedge u_edge (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .scl_in(smb_clk_in),
    .sda_in(smb_data_in),
    .sda_level(sda_level),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  // address from base and strap, next read byte
  assign my_addr = {ccgr_pkg::SLAVE_ADDR_BASE[6:2], addr_sel, ccgr_pkg::SLAVE_ADDR_BASE[0]};
  assign load_byte = first_q ? {3'h0, read_len_q} : reg_rd(index_q);
  assign wr_fire = (state_q == S_ACK) && scl_fall && wr_pend_q;
  assign pd_clear = powerdown && !retain_q;

  // ****************************************
  // serial slave sequencer
  // ****************************************
  // byte framing, acknowledge and read shifting
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= S_IDLE;
      ack_next_q <= S_IDLE;
      cnt_q <= 4'h0;
      shreg_q <= 8'h00;
      tx_q <= 8'h00;
      index_q <= 8'h00;
      wr_left_q <= 8'h00;
      wr_data_q <= 8'h00;
      wr_pend_q <= 1'b0;
      first_q <= 1'b0;
      mack_q <= 1'b0;
      sda_drv_q <= 1'b0;
    end else if (stop_det) begin
      state_q <= S_IDLE;
      sda_drv_q <= 1'b0;
      wr_pend_q <= 1'b0;
    end else if (start_det) begin
      state_q <= S_ADDR;
      cnt_q <= 4'h0;
      sda_drv_q <= 1'b0;
      wr_pend_q <= 1'b0;
    end else begin
      case (state_q)
        S_ADDR, S_INDEX, S_COUNT, S_WDATA: begin
          if (scl_rise) begin
            shreg_q <= {shreg_q[6:0], sda_level};
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == ccgr_pkg::BITS_PER_BYTE) begin
            cnt_q <= 4'h0;
            state_q <= S_ACK;
            sda_drv_q <= 1'b1;
            if (state_q == S_ADDR) begin
              if (shreg_q[7:1] != my_addr) begin
                state_q <= S_IDLE;
                sda_drv_q <= 1'b0;
              end else if (shreg_q[0]) begin
                ack_next_q <= S_RDATA;
                first_q <= 1'b1;
              end else begin
                ack_next_q <= S_INDEX;
              end
            end else if (state_q == S_INDEX) begin
              index_q <= shreg_q;
              ack_next_q <= S_COUNT;
            end else if (state_q == S_COUNT) begin
              wr_left_q <= shreg_q;
              ack_next_q <= S_WDATA;
            end else if (wr_left_q == 8'h00) begin
              state_q <= S_IDLE;
              sda_drv_q <= 1'b0;
            end else begin
              wr_pend_q <= 1'b1;
              wr_data_q <= shreg_q;
              wr_left_q <= wr_left_q - 8'h01;
              ack_next_q <= S_WDATA;
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            sda_drv_q <= 1'b0;
            wr_pend_q <= 1'b0;
            state_q <= ack_next_q;
            if (wr_pend_q) begin
              index_q <= index_q + 8'h01;
            end
            if (ack_next_q == S_RDATA) begin
              tx_q <= load_byte;
              sda_drv_q <= ~load_byte[7];
              first_q <= 1'b0;
              if (!first_q) begin
                index_q <= index_q + 8'h01;
              end
            end
          end
        end
        S_RDATA: begin
          if (scl_rise) begin
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (cnt_q == ccgr_pkg::BITS_PER_BYTE) begin
              cnt_q <= 4'h0;
              sda_drv_q <= 1'b0;
              state_q <= S_RACK;
            end else begin
              tx_q <= {tx_q[6:0], 1'b0};
              sda_drv_q <= ~tx_q[6];
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            mack_q <= ~sda_level;
          end else if (scl_fall) begin
            if (mack_q) begin
              state_q <= S_RDATA;
              tx_q <= load_byte;
              sda_drv_q <= ~load_byte[7];
              first_q <= 1'b0;
              if (!first_q) begin
                index_q <= index_q + 8'h01;
              end
            end else begin
              state_q <= S_IDLE;
            end
          end
        end
        default: begin
          sda_drv_q <= 1'b0;
        end
      endcase
    end
  end

  // open-drain data: only ever pulls low
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sda_out_q <= 1'b0;
    end else begin
      sda_out_q <= 1'b0;
    end
  end

  assign smb_data_oe = sda_drv_q;
  assign smb_data_out = sda_out_q;

  // ****************************************
  // configuration registers
  // ****************************************
  // written at the end of the acknowledge clock
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_slew_sel <= ccgr_pkg::REF_SLEW_RST;
      ref_wake_q <= ccgr_pkg::REF_WAKE_RST;
      ref_en_q <= ccgr_pkg::REF_EN_RST;
      read_len_q <= ccgr_pkg::READ_LEN_RST;
      divider_prog_enable <= DIV_EN_RESET;
      retain_q <= ccgr_pkg::RETAIN_RST;
      stop_sel_q <= ccgr_pkg::STOP_RST;
      out_impedance_sel <= IMP_RESET;
    end else if (pd_clear) begin
      ref_slew_sel <= ccgr_pkg::REF_SLEW_RST;
      ref_wake_q <= ccgr_pkg::REF_WAKE_RST;
      ref_en_q <= ccgr_pkg::REF_EN_RST;
      read_len_q <= ccgr_pkg::READ_LEN_RST;
      divider_prog_enable <= DIV_EN_RESET;
      retain_q <= ccgr_pkg::RETAIN_RST;
      stop_sel_q <= ccgr_pkg::STOP_RST;
      out_impedance_sel <= IMP_RESET;
    end else if (wr_fire) begin
      case (index_q)
        ccgr_pkg::OFF_REF_CTRL: begin
          ref_slew_sel <= wr_data_q[ccgr_pkg::REF_SLEW_LSB +: 2];
          ref_wake_q <= wr_data_q[ccgr_pkg::REF_WAKE_BIT];
          ref_en_q <= wr_data_q[ccgr_pkg::REF_EN_BIT];
        end
        ccgr_pkg::OFF_READ_LEN: begin
          read_len_q <= wr_data_q[ccgr_pkg::READ_LEN_W-1:0];
        end
        ccgr_pkg::OFF_DIV_RETAIN: begin
          divider_prog_enable <= wr_data_q[ccgr_pkg::DIV_EN_BIT];
          retain_q <= wr_data_q[ccgr_pkg::RETAIN_BIT];
        end
        ccgr_pkg::OFF_STOP_STATE: begin
          stop_sel_q <= wr_data_q[1:0];
        end
        ccgr_pkg::OFF_IMPEDANCE: begin
          out_impedance_sel <= wr_data_q;
        end
        default: begin
          read_len_q <= read_len_q;
        end
      endcase
    end
  end

  // ****************************************
  // output control
  // ****************************************
  ccgr_outctl #(
    .NUM_OUT(NUM_OUT)
  ) u_outctl (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .powerdown(powerdown),
    .ref_enable(ref_en_q),
    .ref_wake(ref_wake_q),
    .stop_sel(stop_sel_q),
    .soft_en(out_soft_enable),
    .pin_en_n(out_enable_pin_n),
    .ref_clk_run(ref_clk_run),
    .ref_hold_level(ref_hold_level),
    .ref_hold_hiz(ref_hold_hiz),
    .dif_run(dif_run),
    .dif_stop_true(dif_stop_true),
    .dif_stop_comp(dif_stop_comp),
    .dif_stop_hiz(dif_stop_hiz)
  );

  // ****************************************
  // checks
  // ****************************************
  sequence s_read_open;
    state_q == S_ACK && scl_fall && ack_next_q == S_RDATA && first_q && !stop_det && !start_det;
  endsequence

  sequence s_write_ack;
    state_q == S_ACK && scl_fall && wr_pend_q && !stop_det && !start_det && !pd_clear;
  endsequence

  a_count_first: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_read_open |=> tx_q == {3'h0, $past(read_len_q)} && !first_q)
    else $error("block read did not open with count");

  a_write_after_ack: assert property (@(posedge core_clk) disable iff (!reset_n)
    $changed(out_impedance_sel) |-> $past(wr_fire) || $past(pd_clear))
    else $error("impedance changed outside write or restore");

  a_write_applies: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_write_ack ##0 (index_q == 8'h0C) |=> out_impedance_sel == $past(wr_data_q))
    else $error("acknowledged write not applied");

  a_rev_vendor_ro: assert property (@(posedge core_clk) disable iff (!reset_n)
    reg_rd(8'h05) == {REVISION, VENDOR})
    else $error("revision and vendor byte changed");

  a_class_id_ro: assert property (@(posedge core_clk) disable iff (!reset_n)
    reg_rd(8'h06) == {DEV_CLASS, DEV_ID})
    else $error("class and identifier byte changed");

  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
    reg_rd(8'h04) == 8'h00 && reg_rd(8'h08) == 8'h00 && reg_rd(8'h09) == 8'h00)
    else $error("reserved index reads nonzero");

  a_reserved_bits: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reg_rd(ccgr_pkg::OFF_STOP_STATE) & 8'hFC) == 8'h00 &&
    (reg_rd(ccgr_pkg::OFF_REF_CTRL) & 8'h0F) == 8'h00 &&
    (reg_rd(ccgr_pkg::OFF_READ_LEN) & 8'hE0) == 8'h00 &&
    (reg_rd(ccgr_pkg::OFF_DIV_RETAIN) & 8'h3F) == 8'h00)
    else $error("reserved bits read nonzero");

  a_pd_restore: assert property (@(posedge core_clk) disable iff (!reset_n)
    powerdown && !retain_q |=> read_len_q == 5'h08 && retain_q && stop_sel_q == 2'h0)
    else $error("power-down did not restore defaults");

endmodule

/* tb/ccgr_host.sv */
`timescale 1ns/100ps
// ********
// bus master model
// ********
module ccgr_host (
  input wire logic core_clk, // system clock
  input wire logic sda, // resolved data wire
  output logic scl, // serial clock to device
  output logic pull // high pulls data wire low
);
  localparam int Q = 8;

  // idle bus, data released to pull-up
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end

  // wait whole core cycles
  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // one bit: data set while clock low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    pull <= ~b;
    w(Q);
    scl <= 1'b1;
    w(Q);
    r = sda;
    w(Q);
    scl <= 1'b0;
    w(Q);
  endtask

  // start or repeated start: data falls with clock high
  task automatic start();
    pull <= 1'b0;
    w(Q);
    scl <= 1'b1;
    w(Q);
    pull <= 1'b1;
    w(Q);
    scl <= 1'b0;
    w(Q);
  endtask

  // stop: data rises with clock high, then bus idle
  task automatic stop();
    pull <= 1'b1;
    w(Q);
    scl <= 1'b1;
    w(Q);
    pull <= 1'b0;
    w(Q);
  endtask

  // send a byte msb first, return device ack
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // receive a byte, then ack it or end with nack
  task automatic rx(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, r);
  endtask
endmodule

/* tb/tb_clock_gen_config_registers.sv */
`timescale 1ns/100ps
// ********
// register bank bench
// ********
module tb_clock_gen_config_registers;
  localparam logic [3:0] REV = 4'h6; // arbitrary value
  localparam logic [3:0] VEN = 4'h9; // arbitrary value
  localparam logic [1:0] CLS = 2'h1; // arbitrary value
  localparam logic [5:0] DID = 6'h2A; // arbitrary value
  localparam logic [7:0] ID5 = {REV, VEN};
  localparam logic [7:0] ID6 = {CLS, DID};
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic addr_sel = 1'b0;
  logic powerdown = 1'b0;
  logic [3:0] out_soft_enable = 4'hF;
  logic [3:0] out_enable_pin_n = 4'h0;
  logic smb_clk_in, pull, smb_data_out, smb_data_oe, ref_clk_run, ref_hold_level;
  logic ref_hold_hiz, dif_stop_true, dif_stop_comp, dif_stop_hiz, divider_prog_enable;
  logic [1:0] ref_slew_sel;
  logic [3:0] dif_run;
  logic [7:0] out_impedance_sel;
  logic [7:0] q[$];
  logic [7:0] rst_e[11] = '{8'h08, 8'h50, 8'h00, ID5, ID6, 8'h08, 8'h00, 8'h00, 8'h40,
    8'h00, 8'h55};
  logic [7:0] mid_e[11] = '{8'h03, 8'h20, 8'h00, ID5, ID6, 8'h03, 8'h00, 8'h00, 8'h80,
    8'h00, 8'hE4};
  logic [7:0] ro[5] = '{8'h04, 8'h05, 8'h06, 8'h08, 8'h09};
  logic [7:0] stp[4] = '{8'h00, 8'h09, 8'h04, 8'h12};
  int n_fail = 0;
  int n_checks = 0;

  // open-drain wire with pull-up, output summaries
  wire smb_data_in = ~(pull | (smb_data_oe & ~smb_data_out));
  wire [7:0] st = {2'h0, ref_clk_run, ref_hold_level, ref_hold_hiz, dif_stop_true,
    dif_stop_comp, dif_stop_hiz};
  wire [7:0] misc = {dif_run, 1'b0, divider_prog_enable, ref_slew_sel};

  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;

  ccgr_top #(.IMP_RESET(ccgr_pkg::IMP_85_RST), .REVISION(REV), .VENDOR(VEN),
    .DEV_CLASS(CLS), .DEV_ID(DID)) DUT (.core_clk, .reset_n, .smb_clk_in, .smb_data_in,
    .smb_data_out, .smb_data_oe, .addr_sel, .powerdown, .out_soft_enable, .out_enable_pin_n,
    .ref_clk_run, .ref_hold_level, .ref_hold_hiz, .ref_slew_sel, .dif_run, .dif_stop_true,
    .dif_stop_comp, .dif_stop_hiz, .divider_prog_enable, .out_impedance_sel);

  ccgr_host host (.core_clk, .sda(smb_data_in), .scl(smb_clk_in), .pull);

  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // compare captured read bytes against a table
  task automatic chk_q(input logic [7:0] e[11]);
    foreach (e[i]) chk(q[i], e[i]);
  endtask

  // write one byte at index n, count of one
  task automatic wr(input logic [7:0] n, input logic [7:0] d);
    logic a0, a1, a2, a3;
    host.start();
    host.tx(8'hD0, a0);
    host.tx(n, a1);
    host.tx(8'h01, a2);
    host.tx(d, a3);
    host.stop();
    chk({4'h0, a0, a1, a2, a3}, 8'h0F);
  endtask

  // block read from index n: count byte, then k bytes
  task automatic rd(input logic [7:0] n, input int k);
    logic a0, a1, a2;
    logic [7:0] b;
    q = {};
    host.start();
    host.tx(8'hD0, a0);
    host.tx(n, a1);
    host.start();
    host.tx(8'hD1, a2);
    for (int i = 0; i <= k; i++) begin
      host.rx(i == k, b);
      q.push_back(b);
    end
    host.stop();
    chk({5'h0, a0, a1, a2}, 8'h07);
  endtask

  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(misc, 8'hF1);
    chk(out_impedance_sel, 8'h55);
    rd(8'h03, 10);
    chk_q(rst_e);
    foreach (ro[i]) wr(ro[i], 8'hFF);
    wr(8'h03, 8'h2F);
    wr(8'h07, 8'hE3);
    wr(8'h0C, 8'hE4);
    wr(8'h0A, 8'h80);
    chk(misc, 8'hF4);
    chk(out_impedance_sel, 8'hE4);
    rd(8'h03, 10);
    chk_q(mid_e);
    for (int s = 3; s >= 0; s--) begin
      wr(8'h0B, 8'hFC | 8'(s));
      chk(st, stp[s]);
    end
    wr(8'h0A, 8'hC0);
    wr(8'h03, 8'h70);
    powerdown <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(st, 8'h20);
    chk(misc, 8'h05);
    powerdown <= 1'b0;
    wr(8'h03, 8'h50);
    powerdown <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(st, 8'h00);
    powerdown <= 1'b0;
    out_soft_enable <= 4'hA;
    out_enable_pin_n <= 4'h6;
    repeat (3) @(posedge core_clk);
    chk(misc, 8'h85);
    wr(8'h0A, 8'h00);
    powerdown <= 1'b1;
    repeat (3) @(posedge core_clk);
    powerdown <= 1'b0;
    rd(8'h03, 10);
    chk_q(rst_e);
    close_out();
  end

  // watchdog against a hung bus
  initial begin
    repeat (50000) @(posedge core_clk);
    n_fail++;
    close_out();
  end
endmodule
